// file: rtl/tpwm_consts.svh
// constants of the timer, pulse and watchdog block
// Function
// - divide-enable set: divide counter clock by 2^(code+1), code 0 gives 2, 7 gives 256
// - prescaler divides the selected source only while divide-enable is 1
// - mode field 01 selects pulse generator mode
// - counter starts incrementing once count-enable is written 1
// - pulse mode: match A toggles flip-flop onto output pin, counting continues
// - pulse mode: match B toggles flip-flop again and clears counter
// - writing pulse mode register loads flip-flop with initial value field
// - match A sets status A; timer irq low only while enable A set
// - status B with enable B drives timer irq low; cleared enable masks
// - clearing status A or B releases the timer irq line
// - clock source select picks internal or external clock; internal counts rising
// - external clock counts rising or falling edge per edge select 0 or 1
// - mode field 10 selects watchdog mode
// - watchdog match A sets watchdog status, irq low if enabled; writing 1 ignored
// - writing watchdog clear clears counter, bit returns to 0 by itself
// - count-enable clear stops watchdog only while disable bit is 1
// - watchdog irq enable cannot be cleared while disable bit is 0
// - disable bit self-clears once watchdog is disabled by either method
// - counter read register shows current count
// - interval zero-clear: status set, irq asserted and counter cleared on match cycle
// - watchdog match goes out on its own request line, not on the timer irq used by interval mode
// - mode field 00 selects interval timer mode
// - interval: zero-clear 0 stops at match A, 1 clears and restarts
// - writing 0 to interval status releases irq; writing 1 ignored
`ifndef TPWM_CONSTS_SVH
`define TPWM_CONSTS_SVH
`define TPWM_ADDR_CTRL    8'h00
`define TPWM_ADDR_CMPA    8'h04
`define TPWM_ADDR_CMPB    8'h08
`define TPWM_ADDR_DIV     8'h0C
`define TPWM_ADDR_IVAL    8'h10
`define TPWM_ADDR_PULSE   8'h14
`define TPWM_ADDR_WDOG    8'h18
`define TPWM_ADDR_STAT    8'h1C
`define TPWM_ADDR_COUNT   8'h20
`define TPWM_MODE_IVAL    2'h0
`define TPWM_MODE_PULSE   2'h1
`define TPWM_MODE_WDOG    2'h2
// control register fields
`define TPWM_CTRL_CE      0
`define TPWM_CTRL_CCS     1
`define TPWM_CTRL_DIVEN   2
`define TPWM_CTRL_EDGE    3
`define TPWM_CTRL_MODE    4
// interval mode register
`define TPWM_IVAL_IE      0
`define TPWM_IVAL_ZC      1
// pulse mode register
`define TPWM_PULSE_FFI    0
`define TPWM_PULSE_AE     1
`define TPWM_PULSE_BE     2
// watchdog mode register
`define TPWM_WDOG_IE      0
`define TPWM_WDOG_CLR     1
`define TPWM_WDOG_DIS     2
// status register
`define TPWM_STAT_IVAL    0
`define TPWM_STAT_PA      1
`define TPWM_STAT_PB      2
`define TPWM_STAT_WD      3
`define TPWM_CMPA_RESET   24'hFFFFFF
`define TPWM_CMPB_RESET   24'h0FFFFF
`define TPWM_WATCHDOG_DISABLE_RESET   1'h0
`endif

// file: rtl/tpwm_pkg.sv
// types of the timer, pulse and watchdog block
package tpwm_pkg;
  typedef enum logic [2:0] {
    TPWM_IDLE  = 3'b001,
    TPWM_WDATA = 3'b010,
    TPWM_RDATA = 3'b100
  } tpwm_bus_t;
endpackage : tpwm_pkg

// file: rtl/tpwm_timer.sv
// timer with interval, pulse and watchdog modes behind an ahb-lite slave
`include "tpwm_consts.svh"
module tpwm_timer #(
  parameter int CW = 24
) (
  input  wire logic          core_clk,
  input  wire logic          rst_n,
  input  wire logic          hsel,
  input  wire logic [31:0]   haddr,
  input  wire logic [1:0]    htrans,
  input  wire logic          hwrite,
  input  wire logic [2:0]    hsize,
  input  wire logic [31:0]   hwdata,
  input  wire logic          hready,
  output logic      [31:0]   hrdata,
  output logic               hreadyout,
  output logic               hresp,
  input  wire logic          ext_clk,
  output logic               flipflop_out_pin,
  output logic               timer_irq_n,
  output logic               watchdog_irq_n
);

  if (CW != 24) begin : g_cw_check
    $error("tpwm_timer: counter width must be 24");
  end

  typedef struct packed {
    tpwm_pkg::tpwm_bus_t bus;
    logic [7:0]   addr;
    logic [31:0]  rdata;
    logic         count_enable;
    logic         clock_source_select;
    logic         divide_enable;
    logic         ext_edge_select;
    logic [1:0]   timer_mode_field;
    logic [23:0]  compare_value_a;
    logic [23:0]  compare_value_b;
    logic [2:0]   divide_code;
    logic         interval_irq_enable;
    logic         zero_clear_enable;
    logic         flipflop_initial_value;
    logic         pulse_a_irq_enable;
    logic         pulse_b_irq_enable;
    logic         watchdog_irq_enable;
    logic         watchdog_clear;
    logic         watchdog_disable;
    logic         interval_status;
    logic         pulse_a_status;
    logic         pulse_b_status;
    logic         watchdog_status;
    logic         stopped;
    logic [23:0]  count;
    logic [7:0]   prescale;
    logic [1:0]   ext_sync;
    logic         ext_prev;
    logic         timer_ff;
    logic         timer_irq_n;
    logic         watchdog_irq_n;
  } tpwm_state_t;

  tpwm_state_t s;
  tpwm_state_t next_s;

  function automatic logic [7:0] tpwm_div_mask(input logic [2:0] code);
    tpwm_div_mask = 8'hFF >> (3'h7 - code);
  endfunction : tpwm_div_mask

  logic        wr_take;
  logic        rd_take;
  logic        src_tick;
  logic        tick;
  logic        run;
  logic        match_a;
  logic        match_b;
  logic [31:0] wd;

  //////////////////////////////////////////////////////////////////////////////
  always_comb begin
    next_s = s;
    wd     = hwdata;
    wr_take = 1'b0;
    rd_take = 1'b0;
    // bus: one wait-free slave, data phase follows address phase
    next_s.bus = tpwm_pkg::TPWM_IDLE;
    if (s.bus == tpwm_pkg::TPWM_WDATA) begin
      wr_take = 1'b1;
    end
    if (hsel && htrans[1] && hready) begin
      next_s.addr = haddr[7:0];
      next_s.bus  = hwrite ? tpwm_pkg::TPWM_WDATA : tpwm_pkg::TPWM_RDATA;
      rd_take     = !hwrite;
    end
    // external clock edge detect after two-stage sync
    next_s.ext_sync = {s.ext_sync[0], ext_clk};
    next_s.ext_prev = s.ext_sync[1];
    src_tick = s.clock_source_select ?
               (s.ext_edge_select ? (s.ext_prev && !s.ext_sync[1])
                                  : (!s.ext_prev && s.ext_sync[1])) : 1'b1;
    // count-enable gates every tick; the watchdog lock lives in the write path
    run = s.count_enable && !s.stopped;
    tick = 1'b0;
    if (run && src_tick) begin
      if (s.divide_enable) begin
        next_s.prescale = s.prescale + 8'h01;
        if ((s.prescale & tpwm_div_mask(s.divide_code)) ==
            tpwm_div_mask(s.divide_code)) begin
          tick = 1'b1;
          next_s.prescale = 8'h00;
        end
      end else begin
        tick = 1'b1;
      end
    end
    match_a = tick && (s.count == s.compare_value_a);
    match_b = tick && (s.count == s.compare_value_b);
    if (tick) begin
      next_s.count = s.count + 24'h000001;
    end
    case (s.timer_mode_field)
      `TPWM_MODE_PULSE: begin
        if (match_a) begin
          next_s.timer_ff       = !s.timer_ff;
          next_s.pulse_a_status = 1'b1;
        end
        if (match_b) begin
          next_s.timer_ff       = !s.timer_ff;
          next_s.count          = 24'h000000;
          next_s.pulse_b_status = 1'b1;
        end
      end
      `TPWM_MODE_WDOG: begin
        if (match_a) begin
          next_s.watchdog_status = 1'b1;
          next_s.count           = 24'h000000;
        end
      end
      default: begin
        if (match_a) begin
          next_s.interval_status = 1'b1;
          if (s.zero_clear_enable) begin
            next_s.count = 24'h000000;
          end else begin
            next_s.count   = s.count;
            next_s.stopped = 1'b1;
          end
        end
      end
    endcase
    if (s.watchdog_clear) begin
      next_s.count          = 24'h000000;
      next_s.watchdog_clear = 1'b0;
    end
    // register writes; hardware sets win over software clears
    if (wr_take) begin
      case (s.addr)
        `TPWM_ADDR_CTRL: begin
          // a running watchdog refuses the stop unless its disable bit is set
          next_s.count_enable        = wd[`TPWM_CTRL_CE] ||
            (s.timer_mode_field == `TPWM_MODE_WDOG && s.count_enable &&
             !s.watchdog_disable);
          next_s.clock_source_select = wd[`TPWM_CTRL_CCS];
          next_s.divide_enable       = wd[`TPWM_CTRL_DIVEN];
          next_s.ext_edge_select     = wd[`TPWM_CTRL_EDGE];
          next_s.timer_mode_field    = wd[`TPWM_CTRL_MODE +: 2];
          next_s.stopped             = 1'b0;
          next_s.prescale            = 8'h00;
          if (!wd[`TPWM_CTRL_CE] && s.watchdog_disable) begin
            next_s.watchdog_disable = 1'b0;
          end
        end
        `TPWM_ADDR_CMPA: next_s.compare_value_a = wd[23:0];
        `TPWM_ADDR_CMPB: next_s.compare_value_b = wd[23:0];
        `TPWM_ADDR_DIV:  next_s.divide_code     = wd[2:0];
        `TPWM_ADDR_IVAL: begin
          next_s.interval_irq_enable = wd[`TPWM_IVAL_IE];
          next_s.zero_clear_enable   = wd[`TPWM_IVAL_ZC];
        end
        `TPWM_ADDR_PULSE: begin
          next_s.flipflop_initial_value = wd[`TPWM_PULSE_FFI];
          next_s.pulse_a_irq_enable     = wd[`TPWM_PULSE_AE];
          next_s.pulse_b_irq_enable     = wd[`TPWM_PULSE_BE];
          next_s.timer_ff               = wd[`TPWM_PULSE_FFI];
        end
        `TPWM_ADDR_WDOG: begin
          next_s.watchdog_disable = wd[`TPWM_WDOG_DIS];
          if (wd[`TPWM_WDOG_CLR]) begin
            next_s.watchdog_clear = 1'b1;
          end
          if (wd[`TPWM_WDOG_IE] || !s.watchdog_disable) begin
            next_s.watchdog_irq_enable =
              wd[`TPWM_WDOG_IE] | s.watchdog_irq_enable;
          end else begin
            next_s.watchdog_irq_enable = 1'b0;
            next_s.watchdog_disable    = 1'b0;
          end
        end
        `TPWM_ADDR_STAT: begin
          // only zero writes clear; ones are ignored
          // mode 11 runs as interval, so its match must win as well
          if (!wd[`TPWM_STAT_IVAL] && !(match_a && s.timer_mode_field !=
              `TPWM_MODE_PULSE && s.timer_mode_field != `TPWM_MODE_WDOG)) begin
            next_s.interval_status = 1'b0;
          end
          if (!wd[`TPWM_STAT_PA] && !(match_a &&
              s.timer_mode_field == `TPWM_MODE_PULSE)) begin
            next_s.pulse_a_status = 1'b0;
          end
          if (!wd[`TPWM_STAT_PB] && !(match_b &&
              s.timer_mode_field == `TPWM_MODE_PULSE)) begin
            next_s.pulse_b_status = 1'b0;
          end
        end
        default: begin
        end
      endcase
    end
    // irq lines computed from next state so they move with the status bit
    next_s.timer_irq_n = !((next_s.interval_status && next_s.interval_irq_enable) ||
                           (next_s.pulse_a_status && next_s.pulse_a_irq_enable) ||
                           (next_s.pulse_b_status && next_s.pulse_b_irq_enable));
    next_s.watchdog_irq_n = !(next_s.watchdog_status && next_s.watchdog_irq_enable);
    // read data
    next_s.rdata = 32'h00000000;
    if (rd_take) begin
      case (haddr[7:0])
        `TPWM_ADDR_CTRL:  next_s.rdata = {26'h0, s.timer_mode_field, s.ext_edge_select,
                                          s.divide_enable, s.clock_source_select,
                                          s.count_enable};
        `TPWM_ADDR_CMPA:  next_s.rdata = {8'h00, s.compare_value_a};
        `TPWM_ADDR_CMPB:  next_s.rdata = {8'h00, s.compare_value_b};
        `TPWM_ADDR_DIV:   next_s.rdata = {29'h0, s.divide_code};
        `TPWM_ADDR_IVAL:  next_s.rdata = {30'h0, s.zero_clear_enable,
                                          s.interval_irq_enable};
        `TPWM_ADDR_PULSE: next_s.rdata = {29'h0, s.pulse_b_irq_enable,
                                          s.pulse_a_irq_enable, s.flipflop_initial_value};
        `TPWM_ADDR_WDOG:  next_s.rdata = {29'h0, s.watchdog_disable, s.watchdog_clear,
                                          s.watchdog_irq_enable};
        `TPWM_ADDR_STAT:  next_s.rdata = {28'h0, s.watchdog_status, s.pulse_b_status,
                                          s.pulse_a_status, s.interval_status};
        `TPWM_ADDR_COUNT: next_s.rdata = {8'h00, s.count};
        default:          next_s.rdata = 32'h00000000;
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      s                  <= '0;
      s.bus              <= tpwm_pkg::TPWM_IDLE;
      s.compare_value_a  <= `TPWM_CMPA_RESET;
      s.compare_value_b  <= `TPWM_CMPB_RESET;
      s.watchdog_disable <= `TPWM_WATCHDOG_DISABLE_RESET;
      s.timer_irq_n      <= 1'b1;
      s.watchdog_irq_n   <= 1'b1;
    end else begin
      s <= next_s;
    end
  end

  assign hrdata           = s.rdata;
  assign hreadyout        = 1'b1;
  assign hresp            = 1'b0;
  assign flipflop_out_pin = s.timer_ff;
  assign timer_irq_n      = s.timer_irq_n;
  assign watchdog_irq_n   = s.watchdog_irq_n;

  //////////////////////////////////////////////////////////////////////////////
  a_pulse_a_toggle: assert property (@(posedge core_clk) disable iff (!rst_n)
    (s.timer_mode_field == `TPWM_MODE_PULSE && match_a && !match_b && !wr_take)
      |=> flipflop_out_pin != $past(flipflop_out_pin))
    else $error("pulse flip-flop did not toggle at match A");
  a_pulse_b_clear: assert property (@(posedge core_clk) disable iff (!rst_n)
    (s.timer_mode_field == `TPWM_MODE_PULSE && match_b && !wr_take)
      |=> s.count == 24'h000000)
    else $error("counter not cleared at match B");
  a_ival_status: assert property (@(posedge core_clk) disable iff (!rst_n)
    (s.timer_mode_field == `TPWM_MODE_IVAL && match_a && s.interval_irq_enable)
      |=> s.interval_status && !timer_irq_n)
    else $error("interval match did not raise irq");
  a_ival_stop: assert property (@(posedge core_clk) disable iff (!rst_n)
    (s.stopped && !wr_take && !s.watchdog_clear) |=> $stable(s.count))
    else $error("interval counter moved while stopped");
  a_wdog_irq: assert property (@(posedge core_clk) disable iff (!rst_n)
    (s.watchdog_status && s.watchdog_irq_enable) |-> !watchdog_irq_n)
    else $error("watchdog request not asserted");
  a_wdog_clr_self: assert property (@(posedge core_clk) disable iff (!rst_n)
    s.watchdog_clear && !wr_take |=> !s.watchdog_clear && s.count == 24'h000000)
    else $error("watchdog clear did not clear count");
  a_wdog_ie_lock: assert property (@(posedge core_clk) disable iff (!rst_n)
    (s.watchdog_irq_enable && !s.watchdog_disable) |=> s.watchdog_irq_enable)
    else $error("watchdog enable cleared while locked");
  a_count_hold: assert property (@(posedge core_clk) disable iff (!rst_n)
    (!tick && !s.watchdog_clear && !wr_take) |=> $stable(s.count))
    else $error("counter moved without tick");
  a_div_enable: assert property (@(posedge core_clk) disable iff (!rst_n)
    (run && src_tick && !s.divide_enable) |-> tick)
    else $error("undivided source did not tick");
  a_irq_masked: assert property (@(posedge core_clk) disable iff (!rst_n)
    (!s.interval_irq_enable && !s.pulse_a_irq_enable && !s.pulse_b_irq_enable)
      |-> timer_irq_n)
    else $error("timer irq low with every source masked");
  a_pa_status: assert property (@(posedge core_clk) disable iff (!rst_n)
    (s.timer_mode_field == `TPWM_MODE_PULSE && match_a) |=> s.pulse_a_status)
    else $error("match A did not set pulse A status");
  a_pb_status: assert property (@(posedge core_clk) disable iff (!rst_n)
    (s.timer_mode_field == `TPWM_MODE_PULSE && match_b) |=> s.pulse_b_status)
    else $error("match B did not set pulse B status");
  a_pa_irq: assert property (@(posedge core_clk) disable iff (!rst_n)
    (s.timer_mode_field == `TPWM_MODE_PULSE && match_a && s.pulse_a_irq_enable &&
     !wr_take) |=> !timer_irq_n)
    else $error("enabled match A did not pull timer irq low");
  a_pb_irq: assert property (@(posedge core_clk) disable iff (!rst_n)
    (s.timer_mode_field == `TPWM_MODE_PULSE && match_b && s.pulse_b_irq_enable &&
     !wr_take) |=> !timer_irq_n)
    else $error("enabled match B did not pull timer irq low");
  a_wdog_status: assert property (@(posedge core_clk) disable iff (!rst_n)
    (s.timer_mode_field == `TPWM_MODE_WDOG && match_a) |=> s.watchdog_status)
    else $error("watchdog match did not set status");
  a_wdog_sticky: assert property (@(posedge core_clk) disable iff (!rst_n)
    s.watchdog_status |=> s.watchdog_status)
    else $error("watchdog status cleared by software");
  a_wdog_wrap: assert property (@(posedge core_clk) disable iff (!rst_n)
    (s.timer_mode_field == `TPWM_MODE_WDOG && match_a) |=> s.count == 24'h000000)
    else $error("watchdog match did not restart the count");
  a_ff_init: assert property (@(posedge core_clk) disable iff (!rst_n)
    (wr_take && s.addr == `TPWM_ADDR_PULSE)
      |=> flipflop_out_pin == $past(hwdata[`TPWM_PULSE_FFI]))
    else $error("flip-flop not loaded from initial value");
  a_ce_lock: assert property (@(posedge core_clk) disable iff (!rst_n)
    (s.timer_mode_field == `TPWM_MODE_WDOG && s.count_enable && !s.watchdog_disable)
      |=> s.count_enable)
    else $error("locked watchdog was stopped");
  a_ce_stop: assert property (@(posedge core_clk) disable iff (!rst_n)
    !s.count_enable |-> !tick)
    else $error("tick while count-enable clear");
  a_tick_step: assert property (@(posedge core_clk) disable iff (!rst_n)
    (tick && !match_a && !match_b && !s.watchdog_clear)
      |=> s.count == $past(s.count) + 24'h000001)
    else $error("counter did not advance by one");
  a_ival_hold: assert property (@(posedge core_clk) disable iff (!rst_n)
    (s.timer_mode_field == `TPWM_MODE_IVAL && match_a && !s.zero_clear_enable &&
     !s.watchdog_clear && !wr_take) |=> s.stopped && s.count == $past(s.count))
    else $error("interval count not held at match");
  a_watchdog_disable_self: assert property (@(posedge core_clk) disable iff (!rst_n)
    (wr_take && s.addr == `TPWM_ADDR_CTRL && !hwdata[`TPWM_CTRL_CE] &&
     s.watchdog_disable) |=> !s.watchdog_disable)
    else $error("disable bit kept after stop");
  a_stat_ones: assert property (@(posedge core_clk) disable iff (!rst_n)
    (wr_take && s.addr == `TPWM_ADDR_STAT && hwdata[`TPWM_STAT_IVAL] &&
     s.interval_status) |=> s.interval_status)
    else $error("writing one cleared interval status");
  a_ext_edge: assert property (@(posedge core_clk) disable iff (!rst_n)
    (s.clock_source_select && src_tick) |-> s.ext_sync[1] != s.ext_edge_select)
    else $error("external tick on the wrong edge");
  a_read_count: assert property (@(posedge core_clk) disable iff (!rst_n)
    (rd_take && haddr[7:0] == `TPWM_ADDR_COUNT)
      |=> hrdata == {8'h00, $past(s.count)})
    else $error("count read does not show the counter");

endmodule : tpwm_timer

// file: tb/test_timer_pulse_watchdog_modes.sv
// self-checking bench of the timer, pulse and watchdog block
`include "tpwm_consts.svh"
`define CHECK(g, e) check_val(32'(g), 32'(e))
module test_timer_pulse_watchdog_modes;
  timeunit 1ns;
  timeprecision 100ps;
  logic        core_clk, rst_n, hsel, hwrite, hready, ext_clk;
  logic        hreadyout, hresp, flipflop_out_pin, timer_irq_n, watchdog_irq_n, hit;
  logic [31:0] haddr, hwdata, hrdata, rd, r0;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  int          miscompares, n_checks, cyc;
  tpwm_timer #(.CW(24)) uut (.core_clk(core_clk), .rst_n(rst_n), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .ext_clk(ext_clk),
    .flipflop_out_pin(flipflop_out_pin), .timer_irq_n(timer_irq_n),
    .watchdog_irq_n(watchdog_irq_n));
  // single slave: its ready is the bus ready
  assign hready = hreadyout;
  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end
  ////////////////////////////////////////////////////////////////////////////////
  task automatic check_val(input logic [31:0] g, input logic [31:0] e);
    n_checks++;
    if (g !== e) begin
      miscompares++;
      $display("BAD t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : check_val
  task automatic final_report();
    $display("checks=%0d miscompares=%0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : final_report
  // ready and read data taken at the rising edge, before the slave updates them
  task automatic wait_rdy();
    int n;
    n = 0;
    do begin
      @(posedge core_clk);
      n++;
    end while (hready !== 1'b1 && n < 100);
    rd = hrdata;
    if (n >= 100) miscompares++;
  endtask : wait_rdy
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    haddr  <= {24'h000000, a};
    hwrite <= w;
    htrans <= 2'h2;
    wait_rdy();
    htrans <= 2'h0;
    hwdata <= d;
    wait_rdy();
  endtask : bus
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask : wr
  task automatic rdr(input logic [7:0] a);
    bus(1'b0, a, 32'h00000000);
  endtask : rdr
  task automatic idle(input int n);
    repeat (n) @(posedge core_clk);
  endtask : idle
  function automatic logic pick(input int w);
    case (w)
      0: pick = timer_irq_n;
      1: pick = watchdog_irq_n;
      default: pick = flipflop_out_pin;
    endcase
  endfunction : pick
  task automatic wait_sig(input int w, input logic lvl, input int lim);
    cyc = 0;
    do begin
      @(negedge core_clk);
      cyc++;
    end while (pick(w) !== lvl && cyc < lim);
    hit = pick(w);
    @(posedge core_clk);
  endtask : wait_sig
  ////////////////////////////////////////////////////////////////////////////////
  task automatic t_reset();
    rdr(`TPWM_ADDR_CMPA);
    `CHECK(rd, 32'h00FFFFFF);
    rdr(`TPWM_ADDR_CMPB);
    `CHECK(rd, 32'h000FFFFF);
    rdr(`TPWM_ADDR_COUNT);
    `CHECK(rd, 32'h00000000);
    rdr(8'h24);
    `CHECK(rd, 32'h00000000);
    `CHECK({timer_irq_n, watchdog_irq_n, flipflop_out_pin}, 3'h6);
    `CHECK({hreadyout, hresp}, 2'h2);
  endtask : t_reset
  task automatic t_pulse();
    wr(`TPWM_ADDR_CTRL, 32'h00000010);
    wr(`TPWM_ADDR_CMPA, 32'h00000005);
    wr(`TPWM_ADDR_CMPB, 32'h0000000C);
    wr(`TPWM_ADDR_PULSE, 32'h00000007);
    idle(1);
    `CHECK(flipflop_out_pin, 1'b1);
    wr(`TPWM_ADDR_CTRL, 32'h00000011);
    wait_sig(2, 1'b0, 40);
    `CHECK(hit, 1'b0);
    wait_sig(2, 1'b1, 40);
    `CHECK(cyc, 7);
    wait_sig(2, 1'b0, 40);
    `CHECK(cyc, 6);
    rdr(`TPWM_ADDR_STAT);
    `CHECK(rd[2:1], 2'h3);
    `CHECK(timer_irq_n, 1'b0);
    wr(`TPWM_ADDR_CTRL, 32'h00000010);
    wr(`TPWM_ADDR_PULSE, 32'h00000000);
    idle(1);
    `CHECK(timer_irq_n, 1'b1);
    `CHECK(flipflop_out_pin, 1'b0);
    wr(`TPWM_ADDR_PULSE, 32'h00000004);
    idle(1);
    `CHECK(timer_irq_n, 1'b0);
    wr(`TPWM_ADDR_STAT, 32'h00000003);
    idle(1);
    `CHECK(timer_irq_n, 1'b1);
    wr(`TPWM_ADDR_STAT, 32'h00000000);
  endtask : t_pulse
  task automatic t_interval();
    wr(`TPWM_ADDR_CMPA, 32'h00000014);
    wr(`TPWM_ADDR_IVAL, 32'h00000003);
    wr(`TPWM_ADDR_CTRL, 32'h00000001);
    wait_sig(0, 1'b0, 60);
    `CHECK(hit, 1'b0);
    rdr(`TPWM_ADDR_STAT);
    `CHECK(rd[0], 1'b1);
    rdr(`TPWM_ADDR_COUNT);
    `CHECK(rd < 32'd14, 1'b1);
    wr(`TPWM_ADDR_STAT, 32'h0000000E);
    idle(1);
    `CHECK(timer_irq_n, 1'b1);
    wr(`TPWM_ADDR_CTRL, 32'h00000000);
    wr(`TPWM_ADDR_IVAL, 32'h00000001);
    wr(`TPWM_ADDR_STAT, 32'h00000000);
    wr(`TPWM_ADDR_CTRL, 32'h00000001);
    wait_sig(0, 1'b0, 60);
    `CHECK(hit, 1'b0);
    idle(5);
    rdr(`TPWM_ADDR_COUNT);
    `CHECK(rd, 32'h00000014);
    wr(`TPWM_ADDR_STAT, 32'h00000000);
  endtask : t_interval
  task automatic t_prescale();
    wr(`TPWM_ADDR_CMPA, 32'h00FFFFFF);
    wr(`TPWM_ADDR_IVAL, 32'h00000000);
    wr(`TPWM_ADDR_CTRL, 32'h00000001);
    rdr(`TPWM_ADDR_COUNT);
    r0 = rd;
    idle(8);
    rdr(`TPWM_ADDR_COUNT);
    `CHECK(rd - r0, 32'd10);
    for (int c = 0; c < 8; c++) begin
      wr(`TPWM_ADDR_DIV, 32'(c));
      wr(`TPWM_ADDR_CTRL, 32'h00000005);
      rdr(`TPWM_ADDR_COUNT);
      r0 = rd;
      // reads snapshot two cycles apart more than the idle span
      idle((8 << (c + 1)) - 1);
      rdr(`TPWM_ADDR_COUNT);
      `CHECK(rd - r0, 32'd8);
    end
    wr(`TPWM_ADDR_CTRL, 32'h00000004);
    rdr(`TPWM_ADDR_COUNT);
    r0 = rd;
    idle(20);
    rdr(`TPWM_ADDR_COUNT);
    `CHECK(rd, r0);
  endtask : t_prescale
  task automatic t_extclk();
    for (int e = 0; e < 2; e++) begin
      wr(`TPWM_ADDR_CTRL, 32'h00000003 | 32'(e << 3));
      rdr(`TPWM_ADDR_COUNT);
      r0 = rd;
      repeat (5) begin
        ext_clk <= 1'b1;
        idle(4);
        ext_clk <= 1'b0;
        idle(4);
      end
      idle(6);
      rdr(`TPWM_ADDR_COUNT);
      `CHECK(rd - r0, 32'd5);
    end
  endtask : t_extclk
  task automatic t_watchdog();
    wr(`TPWM_ADDR_CTRL, 32'h00000020);
    wr(`TPWM_ADDR_WDOG, 32'h00000003);
    wr(`TPWM_ADDR_CMPA, 32'h0000001E);
    wr(`TPWM_ADDR_CTRL, 32'h00000021);
    idle(20);
    wr(`TPWM_ADDR_WDOG, 32'h00000003);
    // the clear reaches the counter one cycle after the write lands
    idle(1);
    rdr(`TPWM_ADDR_COUNT);
    `CHECK(rd < 32'd8, 1'b1);
    rdr(`TPWM_ADDR_WDOG);
    `CHECK(rd[1], 1'b0);
    wait_sig(1, 1'b0, 60);
    `CHECK(hit, 1'b0);
    `CHECK(timer_irq_n, 1'b1);
    wr(`TPWM_ADDR_STAT, 32'h0000000F);
    rdr(`TPWM_ADDR_STAT);
    `CHECK(rd[3], 1'b1);
    wr(`TPWM_ADDR_WDOG, 32'h00000000);
    rdr(`TPWM_ADDR_WDOG);
    `CHECK(rd[0], 1'b1);
    wr(`TPWM_ADDR_CTRL, 32'h00000020);
    rdr(`TPWM_ADDR_COUNT);
    r0 = rd;
    idle(3);
    rdr(`TPWM_ADDR_COUNT);
    `CHECK(rd != r0, 1'b1);
    wr(`TPWM_ADDR_WDOG, 32'h00000005);
    wr(`TPWM_ADDR_CTRL, 32'h00000020);
    rdr(`TPWM_ADDR_COUNT);
    r0 = rd;
    idle(5);
    rdr(`TPWM_ADDR_COUNT);
    `CHECK(rd, r0);
    rdr(`TPWM_ADDR_WDOG);
    `CHECK(rd[2], 1'b0);
    wr(`TPWM_ADDR_WDOG, 32'h00000005);
    wr(`TPWM_ADDR_WDOG, 32'h00000004);
    idle(1);
    `CHECK(watchdog_irq_n, 1'b1);
    rdr(`TPWM_ADDR_WDOG);
    `CHECK(rd[2:0], 3'h0);
  endtask : t_watchdog
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    #400000;
    miscompares++;
    final_report();
  end
  initial begin
    rst_n = 1'b0;
    hsel = 1'b1;
    hsize = 3'h2;
    haddr = 32'h00000000;
    htrans = 2'h0;
    hwrite = 1'b0;
    hwdata = 32'h00000000;
    ext_clk = 1'b0;
    miscompares = 0;
    n_checks = 0;
    repeat (3) @(posedge core_clk);
    rst_n <= 1'b1;
    @(posedge core_clk);
    t_reset();
    t_pulse();
    t_interval();
    t_prescale();
    t_extclk();
    t_watchdog();
    final_report();
  end
endmodule : test_timer_pulse_watchdog_modes
